// >>> hw/char_buffer.sv
// Two-entry character buffer with valid and ready on both sides and a flush.
`timescale 1ns/10ps
`default_nettype none
module char_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic rst,
  // Drops every stored entry.
  input  wire logic flush,
  // Filling and draining sides.
  char_stream_if.snk inPort,
  char_stream_if.src outPort
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } buf_state_s;

  buf_state_s q;
  buf_state_s d;
  logic       push;
  logic       pop;

  // Full and empty follow the entry count directly.
  assign inPort.ready  = (q.cnt != CW'(DEPTH));
  assign outPort.valid = (q.cnt != '0);
  assign outPort.data  = q.mem[q.rp];
  assign push          = inPort.valid && inPort.ready;
  assign pop           = outPort.valid && outPort.ready;

  // Pointers wrap at the depth; a flush empties the buffer outright.
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = inPort.data;
      d.wp        = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + PW'(1);
    end
    if (pop) begin
      d.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + PW'(1);
    end
    d.cnt = q.cnt + CW'(push) - CW'(pop);
    if (flush) begin
      d.wp  = '0;
      d.rp  = '0;
      d.cnt = '0;
    end
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  a_count_bounded: assert property (@(posedge sys_clk) disable iff (rst)
    q.cnt <= CW'(DEPTH))
    else $error("Buffer count passed its depth.");

endmodule : char_buffer
`default_nettype wire

// >>> hw/char_stream_if.sv
// Valid/ready carrier for received characters between the unit and its buffer.
`timescale 1ns/10ps
`default_nettype none
interface char_stream_if #(parameter int WIDTH = 8);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : char_stream_if
`default_nettype wire

// >>> hw/serial_line_pkg.sv
// Constants, register selects and state types shared by the serial line unit.
package serial_line_pkg;

  // Clock and default line rate; the bit period is derived from both.
  localparam int CLK_PERIOD_NS = 4;
  localparam int LINE_BAUD     = 9600;
  localparam int BIT_CYCLES    = 1_000_000_000 / (LINE_BAUD * CLK_PERIOD_NS);
  localparam int CNT_W         = 20;
  localparam int CHAR_BITS     = 8;
  localparam int BUF_DEPTH     = 2;

  // Register selects taken from address bits 2 and 1.
  localparam logic [1:0] SEL_RX_STATUS = 2'h0;
  localparam logic [1:0] SEL_RX_BUFFER = 2'h1;
  localparam logic [1:0] SEL_TX_STATUS = 2'h2;
  localparam logic [1:0] SEL_TX_BUFFER = 2'h3;

  // Field positions inside the control/status words.
  localparam int DATASET_BIT = 15;
  localparam int DONE_BIT    = 7;
  localparam int READY_BIT   = 7;
  localparam int IE_BIT      = 6;
  localparam int ADVANCE_BIT = 0;
  localparam int BREAK_BIT   = 0;

  // Positions of the pin inputs inside the synchroniser vector.
  localparam int SYNC_W    = 6;
  localparam int SY_RXD    = 0;
  localparam int SY_CARR   = 1;
  localparam int SY_CTS    = 2;
  localparam int SY_DSR    = 3;
  localparam int SY_INIT   = 4;
  localparam int SY_DCOK   = 5;

  // Values after reset.
  localparam logic [SYNC_W-1:0] SYNC_RST     = 6'h01;
  localparam logic              TX_READY_RST = 1'b1;
  localparam logic              LINE_MARK    = 1'b1;

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

endpackage : serial_line_pkg

// >>> hw/serial_line_unit.sv
// Serial line unit: four program-visible registers over a small serial engine.
`timescale 1ns/10ps
`default_nettype none
module serial_line_unit #(
  parameter int BIT_CYCLES = serial_line_pkg::BIT_CYCLES
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Register access.
  input  wire logic [2:0]  busAddr,
  input  wire logic        busRead,
  input  wire logic        busWrite,
  input  wire logic [15:0] busWrData,
  output logic      [15:0] busRdData,
  output logic             busRdValid,
  // System control levels.
  input  wire logic        busInitialize,
  input  wire logic        dcPowerOk,
  // Interrupt requests.
  output logic             rxIrq,
  output logic             txIrq,
  // Serial line and modem status.
  input  wire logic        rxd,
  output logic             txd,
  output logic             readerAdvance,
  input  wire logic        carrierDetect,
  input  wire logic        clearToSend,
  input  wire logic        dataSetReady
);

  typedef struct packed {
    logic [serial_line_pkg::SYNC_W-1:0]    sync1;
    logic [serial_line_pkg::SYNC_W-1:0]    sync2;
    logic                                  rxIe;
    logic                                  txIe;
    logic                                  brk;
    logic                                  advance;
    logic                                  txReady;
    logic [7:0]                            txHold;
    logic [7:0]                            txShift;
    serial_line_pkg::tx_state_e            txState;
    logic [serial_line_pkg::CNT_W-1:0]     txCnt;
    logic [2:0]                            txBits;
    serial_line_pkg::rx_state_e            rxState;
    logic [serial_line_pkg::CNT_W-1:0]     rxCnt;
    logic [2:0]                            rxBits;
    logic [7:0]                            rxShift;
    logic                                  rxPend;
    logic [7:0]                            rxData;
    logic [15:0]                           rdData;
    logic                                  rdValid;
    logic                                  rxIrq;
    logic                                  txIrq;
    logic                                  txd;
  } unit_state_s;

  localparam logic [serial_line_pkg::CNT_W-1:0] FULL_BIT =
    serial_line_pkg::CNT_W'(BIT_CYCLES - 1);
  localparam logic [serial_line_pkg::CNT_W-1:0] HALF_BIT =
    serial_line_pkg::CNT_W'(BIT_CYCLES / 2 - 1);

  unit_state_s q;
  unit_state_s d;
  logic [1:0]  sel;
  logic        rxdS;
  logic        initS;
  logic        dcokS;
  logic        datasetNow;
  logic        txLine;

  char_stream_if #(.WIDTH(serial_line_pkg::CHAR_BITS)) rxIn ();
  char_stream_if #(.WIDTH(serial_line_pkg::CHAR_BITS)) rxOut ();

  // Received characters wait here until software reads or writes the receive buffer, or power-ok goes low.
  char_buffer #(
    .WIDTH (serial_line_pkg::CHAR_BITS),
    .DEPTH (serial_line_pkg::BUF_DEPTH)
  ) u_rx_buffer (
    .sys_clk (sys_clk),
    .rst     (rst),
    .flush   (!dcokS),
    .inPort  (rxIn.snk),
    .outPort (rxOut.src)
  );

  // Decoded select and synchronised levels; only the second stage is read.
  assign sel         = busAddr[2:1];
  assign rxdS        = q.sync2[serial_line_pkg::SY_RXD];
  assign initS       = q.sync2[serial_line_pkg::SY_INIT];
  assign dcokS       = q.sync2[serial_line_pkg::SY_DCOK];
  assign datasetNow  = q.sync2[serial_line_pkg::SY_CARR] |
                       (q.sync2[serial_line_pkg::SY_CTS] & q.sync2[serial_line_pkg::SY_DSR]);
  assign rxIn.valid  = q.rxPend;
  assign rxIn.data   = q.rxData;
  assign rxOut.ready = (busRead || busWrite) && (sel == serial_line_pkg::SEL_RX_BUFFER);

  // Outputs straight from the state register.
  assign busRdData     = q.rdData;
  assign busRdValid    = q.rdValid;
  assign rxIrq         = q.rxIrq;
  assign txIrq         = q.txIrq;
  assign txd           = q.txd;
  assign readerAdvance = q.advance;

  // Next-state logic: synchronisers, register reads and writes, serial engines.
  always_comb begin
    d         = q;
    d.sync1   = {dcPowerOk, busInitialize, dataSetReady, clearToSend, carrierDetect, rxd};
    d.sync2   = q.sync1;
    d.rdValid = busRead;
    d.rdData  = 16'h0000;
    txLine    = serial_line_pkg::LINE_MARK;

    // Read data; unused and write-only bits read as zero.
    if (busRead) begin
      if (sel == serial_line_pkg::SEL_RX_STATUS) begin
        d.rdData[serial_line_pkg::DATASET_BIT] = datasetNow;
        d.rdData[serial_line_pkg::DONE_BIT]    = rxOut.valid;
        d.rdData[serial_line_pkg::IE_BIT]      = q.rxIe;
      end else if (sel == serial_line_pkg::SEL_RX_BUFFER) begin
        d.rdData[7:0] = rxOut.valid ? rxOut.data : 8'h00;
      end else if (sel == serial_line_pkg::SEL_TX_STATUS) begin
        d.rdData[serial_line_pkg::READY_BIT] = q.txReady;
        d.rdData[serial_line_pkg::IE_BIT]    = q.txIe;
        d.rdData[serial_line_pkg::BREAK_BIT] = q.brk;
      end
    end

    // Transmit engine takes the held character once the line is idle.
    case (q.txState)
      serial_line_pkg::TX_IDLE: begin
        if (!q.txReady) begin
          d.txShift = q.txHold;
          d.txReady = 1'b1;
          d.txCnt   = '0;
          d.txState = serial_line_pkg::TX_START;
        end
      end
      serial_line_pkg::TX_START: begin
        d.txCnt = q.txCnt + 20'h00001;
        if (q.txCnt == FULL_BIT) begin
          d.txCnt   = '0;
          d.txBits  = 3'h0;
          d.txState = serial_line_pkg::TX_DATA;
        end
      end
      serial_line_pkg::TX_DATA: begin
        d.txCnt = q.txCnt + 20'h00001;
        if (q.txCnt == FULL_BIT) begin
          d.txCnt   = '0;
          d.txShift = {1'b0, q.txShift[7:1]};
          d.txBits  = q.txBits + 3'h1;
          if (q.txBits == 3'h7) begin
            d.txState = serial_line_pkg::TX_STOP;
          end
        end
      end
      default: begin
        d.txCnt = q.txCnt + 20'h00001;
        if (q.txCnt == FULL_BIT) begin
          d.txState = serial_line_pkg::TX_IDLE;
        end
      end
    endcase

    // Register writes land after the engine, so a fresh character stays pending.
    if (busWrite) begin
      if (sel == serial_line_pkg::SEL_RX_STATUS) begin
        d.rxIe    = busWrData[serial_line_pkg::IE_BIT];
        d.advance = busWrData[serial_line_pkg::ADVANCE_BIT];
      end else if (sel == serial_line_pkg::SEL_TX_STATUS) begin
        d.txIe = busWrData[serial_line_pkg::IE_BIT];
        d.brk  = busWrData[serial_line_pkg::BREAK_BIT];
      end else if (sel == serial_line_pkg::SEL_TX_BUFFER) begin
        d.txHold  = busWrData[7:0];
        d.txReady = 1'b0;
      end
    end

    // A taken character frees the hand-off slot before a new one may land.
    if (rxIn.ready) begin
      d.rxPend = 1'b0;
    end

    // Receive engine samples mid-bit; a false start returns to idle.
    case (q.rxState)
      serial_line_pkg::RX_IDLE: begin
        if (!rxdS) begin
          d.advance = 1'b0;
          d.rxCnt   = '0;
          d.rxState = serial_line_pkg::RX_START;
        end
      end
      serial_line_pkg::RX_START: begin
        d.rxCnt = q.rxCnt + 20'h00001;
        if (q.rxCnt == HALF_BIT) begin
          d.rxCnt   = '0;
          d.rxBits  = 3'h0;
          d.rxState = rxdS ? serial_line_pkg::RX_IDLE : serial_line_pkg::RX_DATA;
        end
      end
      serial_line_pkg::RX_DATA: begin
        d.rxCnt = q.rxCnt + 20'h00001;
        if (q.rxCnt == FULL_BIT) begin
          d.rxCnt   = '0;
          d.rxShift = {rxdS, q.rxShift[7:1]};
          d.rxBits  = q.rxBits + 3'h1;
          if (q.rxBits == 3'h7) begin
            d.rxState = serial_line_pkg::RX_STOP;
          end
        end
      end
      default: begin
        d.rxCnt = q.rxCnt + 20'h00001;
        if (q.rxCnt == FULL_BIT) begin
          d.rxState = serial_line_pkg::RX_IDLE;
          if (rxdS) begin
            d.rxPend = 1'b1;
            d.rxData = q.rxShift;
          end
        end
      end
    endcase

    // Bus initialize clears the control bits; power-ok low forces ready.
    if (initS) begin
      d.rxIe    = 1'b0;
      d.txIe    = 1'b0;
      d.brk     = 1'b0;
      d.advance = 1'b0;
    end
    if (!dcokS) begin
      d.txReady = 1'b1;
      d.rxPend  = 1'b0;
    end

    // Line level and interrupt levels.
    if (d.txState == serial_line_pkg::TX_START) begin
      txLine = 1'b0;
    end else if (d.txState == serial_line_pkg::TX_DATA) begin
      txLine = d.txShift[0];
    end
    d.txd   = d.brk ? 1'b0 : txLine;
    d.rxIrq = rxOut.valid && q.rxIe;
    d.txIrq = q.txReady && q.txIe;
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q         <= '0;
      q.sync1   <= serial_line_pkg::SYNC_RST;
      q.sync2   <= serial_line_pkg::SYNC_RST;
      q.txReady <= serial_line_pkg::TX_READY_RST;
      q.txd     <= serial_line_pkg::LINE_MARK;
    end else begin
      q <= d;
    end
  end

  a_dataset_read: assert property (@(posedge sys_clk) disable iff (rst)
    (busRead && sel == serial_line_pkg::SEL_RX_STATUS) |=> busRdData[15] == $past(datasetNow))
    else $error("Dataset status read back wrong.");

  a_unused_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (busRead && sel != serial_line_pkg::SEL_RX_BUFFER) |=> busRdData[14:8] == 7'h00 && busRdData[5:1] == 5'h00)
    else $error("Unused status bits not zero.");

  a_rxbuf_high_zero: assert property (@(posedge sys_clk) disable iff (rst)
    (busRead && sel == serial_line_pkg::SEL_RX_BUFFER) |=> busRdData[15:8] == 8'h00)
    else $error("Receive buffer high byte not zero.");

  a_done_dropped: assert property (@(posedge sys_clk) disable iff (rst)
    !dcokS |=> !rxOut.valid)
    else $error("Receiver done survived power-ok low.");

  a_rx_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 rxIrq == $past(rxOut.valid && q.rxIe))
    else $error("Receiver request does not follow done and enable.");

  a_init_clears: assert property (@(posedge sys_clk) disable iff (rst)
    initS |=> !q.rxIe && !q.txIe && !q.brk)
    else $error("Bus initialize left a control bit set.");

  a_advance_start: assert property (@(posedge sys_clk) disable iff (rst)
    (q.rxState == serial_line_pkg::RX_IDLE && !rxdS) |=> !readerAdvance)
    else $error("Reader advance not cleared by start bit.");

  a_ready_powerup: assert property (@(posedge sys_clk) disable iff (rst)
    !dcokS |=> q.txReady)
    else $error("Transmit ready not forced during power-up.");

  a_ready_on_load: assert property (@(posedge sys_clk) disable iff (rst)
    (busWrite && sel == serial_line_pkg::SEL_TX_BUFFER && dcokS) |=> !q.txReady)
    else $error("Transmit ready still set after a load.");

  a_tx_irq_level: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 txIrq == $past(q.txReady && q.txIe))
    else $error("Transmitter request does not follow ready and enable.");

  a_break_space: assert property (@(posedge sys_clk) disable iff (rst)
    q.brk |-> !txd)
    else $error("Line not at space during break.");

endmodule : serial_line_unit
`default_nettype wire

// >>> tb/serial_terminal.sv
// Terminal model on the far side of the serial line: sends frames and decodes received ones.
`timescale 1ns/10ps
`default_nettype none
module serial_terminal #(
  parameter int BIT_CYCLES = 8
) (
  // Clock.
  input  wire logic sys_clk,
  // Serial line.
  input  wire logic txd,
  output var  logic rxd
);
  logic [7:0] got[$];
  logic [7:0] sh;

  // The line rests at mark between frames.
  initial rxd = 1'b1;

  // Sends one frame: start bit, eight bits lowest first, one stop bit.
  task automatic send_char(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      #1 rxd = f[i];
      repeat (BIT_CYCLES - 1) @(posedge sys_clk);
    end
  endtask : send_char

  // Decodes frames from the transmit line; a frame without a valid stop bit is dropped.
  always begin : decode
    @(negedge txd);
    repeat (BIT_CYCLES / 2) @(posedge sys_clk);
    if (txd === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYCLES) @(posedge sys_clk);
        sh[i] = txd;
      end
      repeat (BIT_CYCLES) @(posedge sys_clk);
      if (txd === 1'b1) got.push_back(sh);
    end
  end
endmodule : serial_terminal
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the serial line unit with a terminal model on its line.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int BITS = 8;
  logic        sys_clk, rst, busRead, busWrite, busRdValid, busInitialize, dcPowerOk;
  logic        rxIrq, txIrq, rxd, txd, readerAdvance, carrierDetect, clearToSend, dataSetReady;
  logic [2:0]  busAddr;
  logic [15:0] busWrData, busRdData;
  int          mismatches, compares;

  // Design under test with a short bit period.
  serial_line_unit #(.BIT_CYCLES(BITS)) dut (
    .sys_clk(sys_clk), .rst(rst), .busAddr(busAddr), .busRead(busRead), .busWrite(busWrite),
    .busWrData(busWrData), .busRdData(busRdData), .busRdValid(busRdValid),
    .busInitialize(busInitialize), .dcPowerOk(dcPowerOk), .rxIrq(rxIrq), .txIrq(txIrq),
    .rxd(rxd), .txd(txd), .readerAdvance(readerAdvance), .carrierDetect(carrierDetect),
    .clearToSend(clearToSend), .dataSetReady(dataSetReady));

  // Attached terminal.
  serial_terminal #(.BIT_CYCLES(BITS)) term (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));

  // Clock at 250 MHz.
  always #2 sys_clk = ~sys_clk;

  // Compares a seen value with the expected one and counts both outcomes.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // Expected receiver status word from the modem levels and the flags.
  function automatic logic [15:0] rx_stat(input logic done, input logic ie);
    return {carrierDetect | (clearToSend & dataSetReady), 7'h00, done, ie, 6'h00};
  endfunction : rx_stat

  // Expected transmitter status word.
  function automatic logic [15:0] tx_stat(input logic rdy, input logic ie, input logic brk);
    return {8'h00, rdy, ie, 5'h00, brk};
  endfunction : tx_stat

  // One-cycle write; address bit 0 is random since the unit ignores it.
  task automatic bus_wr(input logic [1:0] sel, input logic [15:0] d);
    @(posedge sys_clk);
    #1 busWrite = 1'b1;
    busAddr = {sel, 1'($urandom)};
    busWrData = d;
    @(posedge sys_clk);
    #1 busWrite = 1'b0;
  endtask : bus_wr

  // One-cycle read; the answer is taken in the cycle after the strobe.
  task automatic rd_chk(input logic [1:0] sel, input logic [15:0] exp);
    @(posedge sys_clk);
    #1 busRead = 1'b1;
    busAddr = {sel, 1'($urandom)};
    @(posedge sys_clk);
    #1 busRead = 1'b0;
    check({15'h0000, busRdValid}, 16'h0001);
    check(busRdData, exp);
  endtask : rd_chk

  // Waits for the receive request or for k decoded characters, under a bound.
  task automatic wait_ev(input bit m, input int k);
    int n;
    n = 0;
    while ((m ? term.got.size() < k : rxIrq !== 1'b1) && n < 1000) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n >= 1000) begin
      mismatches++;
      report_and_stop();
    end
  endtask : wait_ev

  // Main sequence: reset, then one scenario after another.
  initial begin : main
    logic [7:0] ca, cb;
    sys_clk = 1'b0;
    rst = 1'b1;
    {busRead, busWrite, busAddr, busWrData, busInitialize} = '0;
    {carrierDetect, clearToSend, dataSetReady} = 3'h0;
    dcPowerOk = 1'b1;
    mismatches = 0;
    compares = 0;
    void'($urandom(32'h0a94));
    repeat (6) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 check({13'h0000, rxIrq, txIrq, txd}, 16'h0001);
    rd_chk(2'h0, rx_stat(1'b0, 1'b0));
    rd_chk(2'h1, 16'h0000);
    rd_chk(2'h2, tx_stat(1'b1, 1'b0, 1'b0));
    // Every modem level combination, read after the synchronisers settle.
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      #1 {carrierDetect, clearToSend, dataSetReady} = 3'(i);
      repeat (4) @(posedge sys_clk);
      rd_chk(2'h0, rx_stat(1'b0, 1'b0));
    end
    // All writable bits set except reader advance; unused bits must still read zero.
    bus_wr(2'h0, 16'hfffe);
    bus_wr(2'h2, 16'hffff);
    rd_chk(2'h0, rx_stat(1'b0, 1'b1));
    rd_chk(2'h2, tx_stat(1'b1, 1'b1, 1'b1));
    check({14'h0000, txd, txIrq}, 16'h0001);
    check({15'h0000, rxIrq}, 16'h0000);
    repeat (100) @(posedge sys_clk);
    bus_wr(2'h2, 16'h0040);
    rd_chk(2'h2, tx_stat(1'b1, 1'b1, 1'b0));
    // Two characters back to back; the second waits in the buffer.
    ca = 8'($urandom);
    cb = 8'($urandom);
    term.got.delete();
    bus_wr(2'h3, {8'($urandom), ca});
    repeat (4) @(posedge sys_clk);
    bus_wr(2'h3, {8'h00, cb});
    repeat (2) @(posedge sys_clk);
    #1 check({15'h0000, txIrq}, 16'h0000);
    rd_chk(2'h2, tx_stat(1'b0, 1'b1, 1'b0));
    wait_ev(1'b1, 2);
    check({term.got[0], term.got[1]}, {ca, cb});
    check({15'h0000, txIrq}, 16'h0001);
    // Reader advance, then a random character received and taken.
    for (int i = 0; i < 3; i++) begin
      bus_wr(2'h0, 16'h0041);
      check({15'h0000, readerAdvance}, 16'h0001);
      rd_chk(2'h0, rx_stat(1'b0, 1'b1));
      ca = 8'($urandom);
      term.send_char(ca);
      #1 check({15'h0000, readerAdvance}, 16'h0000);
      wait_ev(1'b0, 0);
      rd_chk(2'h0, rx_stat(1'b1, 1'b1));
      rd_chk(2'h1, {8'h00, ca});
      repeat (3) @(posedge sys_clk);
      #1 check({15'h0000, rxIrq}, 16'h0000);
      rd_chk(2'h0, rx_stat(1'b0, 1'b1));
    end
    // Two characters queued; done stays set after the first is taken.
    ca = 8'($urandom);
    cb = 8'($urandom);
    term.send_char(ca);
    term.send_char(cb);
    repeat (2 * BITS) @(posedge sys_clk);
    rd_chk(2'h1, {8'h00, ca});
    rd_chk(2'h0, rx_stat(1'b1, 1'b1));
    rd_chk(2'h1, {8'h00, cb});
    rd_chk(2'h0, rx_stat(1'b0, 1'b1));
    // Bus initialize clears both enables and the break bit.
    bus_wr(2'h2, 16'h0041);
    @(posedge sys_clk);
    #1 busInitialize = 1'b1;
    check({15'h0000, txIrq}, 16'h0001);
    repeat (4) @(posedge sys_clk);
    #1 busInitialize = 1'b0;
    repeat (4) @(posedge sys_clk);
    rd_chk(2'h0, rx_stat(1'b0, 1'b0));
    rd_chk(2'h2, tx_stat(1'b1, 1'b0, 1'b0));
    check({15'h0000, txIrq}, 16'h0000);
    // Power-ok low empties the receiver and forces transmit ready.
    term.send_char(8'($urandom));
    repeat (2 * BITS) @(posedge sys_clk);
    rd_chk(2'h0, rx_stat(1'b1, 1'b0));
    // A write to the receive buffer also takes the waiting character.
    bus_wr(2'h1, 16'h0000);
    rd_chk(2'h0, rx_stat(1'b0, 1'b0));
    term.send_char(8'($urandom));
    repeat (2 * BITS) @(posedge sys_clk);
    rd_chk(2'h0, rx_stat(1'b1, 1'b0));
    bus_wr(2'h3, 16'h00a5);
    bus_wr(2'h3, 16'h005a);
    @(posedge sys_clk);
    #1 dcPowerOk = 1'b0;
    repeat (4) @(posedge sys_clk);
    rd_chk(2'h2, tx_stat(1'b1, 1'b0, 1'b0));
    rd_chk(2'h0, rx_stat(1'b0, 1'b0));
    @(posedge sys_clk);
    #1 dcPowerOk = 1'b1;
    repeat (4) @(posedge sys_clk);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
